// *** logic/search_pulse_pkg.sv ***
// constants, state codes and status layout for the search-assist and pulse command block
package search_pulse_pkg;

    // command byte layout
    localparam int          CMD_BIT_MARK   = 0;
    localparam int          CMD_BIT_ARM    = 1;
    localparam int          CMD_BIT_SEL_LO = 2;
    localparam int          CMD_BIT_FLAG   = 4;
    localparam int          CMD_BIT_FN_LO  = 5;
    localparam logic [2:0]  FUNC_SEARCH    = 3'h5;
    localparam logic [2:0]  FUNC_PULSE     = 3'h7;
    localparam logic [1:0]  PULSE_SEL      = 2'h3;

    // fixed codes
    localparam logic [7:0]  CODE_TERM      = 8'hf1;
    localparam logic [7:0]  CODE_END_HI    = 8'hf6;
    localparam logic [7:0]  CODE_END_LO    = 8'h76;
    localparam logic [7:0]  ECHO_UNDEF     = 8'h03;

    // slot sequencing
    localparam logic [1:0]  SUB_READ0      = 2'h0;
    localparam logic [1:0]  SUB_READ1      = 2'h1;
    localparam logic [1:0]  SUB_WRITE      = 2'h2;
    localparam logic [2:0]  LAST_POS       = 3'h3;
    localparam logic [2:0]  LAST_BIT       = 3'h7;

    // register map
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_SOFF_BIT  = 1;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
    localparam logic [1:0]  SPEED_RESET    = 2'h0;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SLOT  = 4'b0010,
        ST_TX    = 4'b0100,
        ST_PULSE = 4'b1000
    } state_e;

    typedef struct packed {
        state_e     state;
        logic [1:0] pad;
        logic       pulse_on;
        logic       err;
        logic [1:0] speed;
        logic       pulse12;
        logic       arm;
        logic       search_on;
    } status_s;

endpackage

// *** logic/search_pulse_cmds.sv ***
// search-assist engine and pulse command interpreter with apb status/control
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - search-assist command copies command bit 4 into the search flag
// - with search on, each data byte becomes twelve bus slots
// - search-assist command sends no response byte
// - search-assist command speed field takes effect at once, no bus activity
// - pulse command bit 1 arms or disarms pullup after each data byte outside search mode
// - pulse command bit 4 picks 5V pullup (0) or 12V pulse (1)
// - F1h in command mode ends a pulse-command pulse early; data-byte pullups run to pulse_end
// - pulse command response sent only once the pulse is over
// - pulse response echoes command, two low bits undefined
// - armed data-mode pullup end reports F6h if byte msb set, else 76h
// - pullup-end code is an extra byte after the data response
// - per identity position: read two slots, decide, write one slot
// - search returns selected identity and conflict positions
// - a pass returns 128 bits as 16 bytes
// - one response byte for each byte received in search mode
// - reserved reset-response bit undefined; host ignores it
// - write direction on conflict, first read if none, 1 on no response
// - after a bus error returned identity bits read 1 until search off
// - conflict flag set on conflict or no response; direction is written bit
// - four positions per byte, lowest in low pair, flags even, directions odd
module search_pulse_cmds (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        data_mode,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    output logic             slot_req,
    output logic             slot_wbit,
    input  wire logic        slot_done,
    input  wire logic        slot_rbit,
    output logic             pulse_on,
    output logic             pulse_12v,
    input  wire logic        pulse_end,
    output logic      [1:0]  speed,
    output logic             search_on,
    output logic             cmd_fwd_valid,
    output logic      [7:0]  cmd_fwd_byte
);

    function automatic logic is_search_cmd(input logic [7:0] b);
        return b[search_pulse_pkg::CMD_BIT_MARK]
            && (b[7:search_pulse_pkg::CMD_BIT_FN_LO] == search_pulse_pkg::FUNC_SEARCH);
    endfunction

    function automatic logic is_pulse_cmd(input logic [7:0] b);
        return b[search_pulse_pkg::CMD_BIT_MARK]
            && (b[7:search_pulse_pkg::CMD_BIT_FN_LO] == search_pulse_pkg::FUNC_PULSE)
            && (b[search_pulse_pkg::CMD_BIT_SEL_LO +: 2] == search_pulse_pkg::PULSE_SEL);
    endfunction

    search_pulse_pkg::state_e state_reg;
    logic        ctrl_en_reg;
    logic        search_reg;
    logic        arm_reg;
    logic        pulse12_reg;
    logic [1:0]  speed_reg;
    logic        err_reg;
    logic        pulse_on_reg;
    logic        pulse_data_reg;
    logic        chain_reg;
    logic        searching_reg;
    logic [7:0]  byte_reg;
    logic [7:0]  acc_reg;
    logic [7:0]  echo_reg;
    logic [7:0]  tx_data_reg;
    logic [2:0]  pos_reg;
    logic [1:0]  sub_reg;
    logic        b0_reg;
    logic        d_reg;
    logic        wbit_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic        fwd_valid_reg;
    logic [7:0]  fwd_byte_reg;

    logic        rx_fire;
    logic        cmd_fire;
    logic        data_fire;
    logic        step;
    logic        conflict;
    logic        noresp;
    logic        dir_bit;
    logic        rprime;
    logic        err_set;
    logic        term;
    logic        apb_wr;
    logic        soff;
    search_pulse_pkg::status_s status;

    ////////////////////////////////////////////////////////////////////////////
    // handshakes and decode

    assign rx_ready  = ctrl_en_reg
                    && ((state_reg == search_pulse_pkg::ST_IDLE)
                    || ((state_reg == search_pulse_pkg::ST_PULSE) && !pulse_data_reg && !data_mode));
    assign rx_fire   = rx_valid && rx_ready;
    assign cmd_fire  = rx_fire && (state_reg == search_pulse_pkg::ST_IDLE) && !data_mode;
    assign data_fire = rx_fire && (state_reg == search_pulse_pkg::ST_IDLE) && data_mode;
    assign step      = (state_reg == search_pulse_pkg::ST_SLOT) && slot_done;

    // b0 and b1 both 0 means both polarities answered
    assign conflict = !b0_reg && !slot_rbit;
    assign noresp   = b0_reg && slot_rbit;
    assign dir_bit  = conflict ? byte_reg[1] : (noresp ? 1'b1 : b0_reg);
    assign rprime   = err_reg ? 1'b1 : wbit_reg;
    assign err_set  = step && searching_reg && (sub_reg == search_pulse_pkg::SUB_READ1) && noresp;

    // termination heard only in a command-mode pulse
    assign term = rx_fire && (state_reg == search_pulse_pkg::ST_PULSE)
               && (rx_data == search_pulse_pkg::CODE_TERM);

    assign tx_valid  = (state_reg == search_pulse_pkg::ST_TX);
    assign tx_data   = tx_data_reg;
    assign slot_req  = (state_reg == search_pulse_pkg::ST_SLOT);
    assign slot_wbit = wbit_reg;
    assign pulse_on  = pulse_on_reg;
    assign pulse_12v = pulse12_reg;
    assign speed     = speed_reg;
    assign search_on = search_reg;
    assign cmd_fwd_valid = fwd_valid_reg;
    assign cmd_fwd_byte  = fwd_byte_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: data latched in setup, no wait states

    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;
    assign apb_wr  = psel && penable && pwrite;
    assign soff    = apb_wr && (paddr == search_pulse_pkg::ADDR_CTRL)
                  && pwdata[search_pulse_pkg::CTRL_SOFF_BIT];

    always_comb begin
        status           = '0;
        status.state     = state_reg;
        status.pulse_on  = pulse_on_reg;
        status.err       = err_reg;
        status.speed     = speed_reg;
        status.pulse12   = pulse12_reg;
        status.arm       = arm_reg;
        status.search_on = search_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            case (paddr)
                search_pulse_pkg::ADDR_CTRL: begin
                    if (!pwrite) begin
                        prdata_reg <= {31'h0000_0000, ctrl_en_reg};
                    end
                end
                search_pulse_pkg::ADDR_STATUS: begin
                    if (!pwrite) begin
                        prdata_reg <= {19'h0_0000, status};
                    end else begin
                        pslverr_reg <= 1'b1;
                    end
                end
                default: begin
                    pslverr_reg <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_en_reg <= search_pulse_pkg::CTRL_RESET[search_pulse_pkg::CTRL_EN_BIT];
        end else if (apb_wr && (paddr == search_pulse_pkg::ADDR_CTRL)) begin
            ctrl_en_reg <= pwdata[search_pulse_pkg::CTRL_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode flags

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            search_reg  <= 1'b0;
            arm_reg     <= 1'b0;
            pulse12_reg <= 1'b0;
            speed_reg   <= search_pulse_pkg::SPEED_RESET;
        end else if (cmd_fire && is_search_cmd(rx_data)) begin
            // no bus activity; speed moves at once
            search_reg <= rx_data[search_pulse_pkg::CMD_BIT_FLAG];
            speed_reg  <= rx_data[search_pulse_pkg::CMD_BIT_SEL_LO +: 2];
        end else if (cmd_fire && is_pulse_cmd(rx_data)) begin
            arm_reg     <= rx_data[search_pulse_pkg::CMD_BIT_ARM];
            pulse12_reg <= rx_data[search_pulse_pkg::CMD_BIT_FLAG];
        end else if (soff) begin
            search_reg <= 1'b0;
        end
    end

    // sticky error: set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= 1'b0;
        end else if (err_set) begin
            err_reg <= 1'b1;
        end else if (soff || (cmd_fire && is_search_cmd(rx_data)
                     && !rx_data[search_pulse_pkg::CMD_BIT_FLAG])) begin
            err_reg <= 1'b0;
        end
    end

    // other command codes belong to neighbouring logic, which also owns
    // the undefined reserved bit of its reset answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_valid_reg <= 1'b0;
            fwd_byte_reg  <= 8'h00;
        end else begin
            fwd_valid_reg <= cmd_fire && !is_search_cmd(rx_data) && !is_pulse_cmd(rx_data);
            if (cmd_fire) begin
                fwd_byte_reg <= rx_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte sequencer, slots, responses and pulses

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= search_pulse_pkg::ST_IDLE;
            byte_reg       <= 8'h00;
            acc_reg        <= 8'h00;
            echo_reg       <= 8'h00;
            tx_data_reg    <= 8'h00;
            pos_reg        <= 3'h0;
            sub_reg        <= search_pulse_pkg::SUB_READ0;
            b0_reg         <= 1'b0;
            d_reg          <= 1'b0;
            wbit_reg       <= 1'b1;
            chain_reg      <= 1'b0;
            searching_reg  <= 1'b0;
            pulse_on_reg   <= 1'b0;
            pulse_data_reg <= 1'b0;
        end else begin
            case (state_reg)
                search_pulse_pkg::ST_IDLE: begin
                    if (data_fire) begin
                        byte_reg      <= rx_data;
                        pos_reg       <= 3'h0;
                        sub_reg       <= search_pulse_pkg::SUB_READ0;
                        searching_reg <= search_reg;
                        // read slot = write-1 slot
                        wbit_reg      <= search_reg ? 1'b1 : rx_data[0];
                        state_reg     <= search_pulse_pkg::ST_SLOT;
                    end else if (cmd_fire && is_pulse_cmd(rx_data)) begin
                        // undefined echo bits driven 0
                        echo_reg       <= rx_data & ~search_pulse_pkg::ECHO_UNDEF;
                        pulse_on_reg   <= 1'b1;
                        pulse_data_reg <= 1'b0;
                        state_reg      <= search_pulse_pkg::ST_PULSE;
                    end
                end
                search_pulse_pkg::ST_SLOT: begin
                    if (step && !searching_reg) begin
                        // plain byte, lsb first
                        acc_reg  <= {slot_rbit, acc_reg[7:1]};
                        byte_reg <= {1'b0, byte_reg[7:1]};
                        wbit_reg <= byte_reg[1];
                        pos_reg  <= pos_reg + 3'h1;
                        if (pos_reg == search_pulse_pkg::LAST_BIT) begin
                            tx_data_reg <= {slot_rbit, acc_reg[7:1]};
                            chain_reg   <= arm_reg;
                            state_reg   <= search_pulse_pkg::ST_TX;
                        end
                    end else if (step) begin
                        case (sub_reg)
                            search_pulse_pkg::SUB_READ0: begin
                                b0_reg   <= slot_rbit;
                                wbit_reg <= 1'b1;
                                sub_reg  <= search_pulse_pkg::SUB_READ1;
                            end
                            search_pulse_pkg::SUB_READ1: begin
                                wbit_reg <= dir_bit;
                                d_reg    <= conflict || noresp;
                                sub_reg  <= search_pulse_pkg::SUB_WRITE;
                            end
                            search_pulse_pkg::SUB_WRITE: begin
                                // pair {direction, flag} shifts in from the top
                                acc_reg  <= {rprime, d_reg, acc_reg[7:2]};
                                byte_reg <= {2'h0, byte_reg[7:2]};
                                wbit_reg <= 1'b1;
                                sub_reg  <= search_pulse_pkg::SUB_READ0;
                                pos_reg  <= pos_reg + 3'h1;
                                if (pos_reg == search_pulse_pkg::LAST_POS) begin
                                    // answer only after the twelfth slot
                                    tx_data_reg <= {rprime, d_reg, acc_reg[7:2]};
                                    chain_reg   <= 1'b0;
                                    state_reg   <= search_pulse_pkg::ST_TX;
                                end
                            end
                            default: begin
                                sub_reg <= search_pulse_pkg::SUB_READ0;
                            end
                        endcase
                    end
                end
                search_pulse_pkg::ST_TX: begin
                    if (tx_ready) begin
                        if (chain_reg) begin
                            // duration set outside; never unlimited here
                            pulse_on_reg   <= 1'b1;
                            pulse_data_reg <= 1'b1;
                            chain_reg      <= 1'b0;
                            state_reg      <= search_pulse_pkg::ST_PULSE;
                        end else begin
                            state_reg <= search_pulse_pkg::ST_IDLE;
                        end
                    end
                end
                search_pulse_pkg::ST_PULSE: begin
                    if (pulse_end || term) begin
                        pulse_on_reg <= 1'b0;
                        state_reg    <= search_pulse_pkg::ST_TX;
                        if (pulse_data_reg) begin
                            // tx_data_reg holds the data answer
                            tx_data_reg <= tx_data_reg[7] ? search_pulse_pkg::CODE_END_HI
                                                          : search_pulse_pkg::CODE_END_LO;
                        end else begin
                            tx_data_reg <= echo_reg;
                        end
                    end
                end
                default: begin
                    state_reg    <= search_pulse_pkg::ST_IDLE;
                    pulse_on_reg <= 1'b0;
                end
            endcase
        end
    end

endmodule

// *** testbench/bus_slaves_model.sv ***
// slot-level model of the slaves on the single-wire bus
`timescale 1ns/1ps
module bus_slaves_model (
    input  wire logic        clk,
    input  wire logic        slot_req,
    input  wire logic        slot_wbit,
    input  wire logic [11:0] rpat,
    input  wire logic [1:0]  lat,
    output logic             slot_done,
    output logic             slot_rbit,
    output logic      [11:0] wlog
);
    logic [1:0] wait_cnt;
    logic [3:0] idx;
    logic       last = 1'b0;
    // released line shows the inverse
    assign slot_rbit = slot_done ? last : ~last;
    always @(posedge clk) begin
        slot_done <= 1'b0;
        if (!slot_req) begin
            idx      <= 4'h0;
            wait_cnt <= 2'h0;
        end else if (!slot_done) begin
            if (wait_cnt != lat) begin
                wait_cnt <= wait_cnt + 2'h1;
            end else begin
                wait_cnt  <= 2'h0;
                slot_done <= 1'b1;
                last      <= rpat[idx] & slot_wbit;  // a write-0 slot reads back 0
                wlog[idx] <= slot_wbit;
                idx       <= idx + 4'h1;
            end
        end
    end
endmodule

// *** testbench/search_pulse_cmds_asserts.sv ***
// concurrent checks for the search-assist and pulse command block
`timescale 1ns/1ps
module search_pulse_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       data_mode,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       rx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_ready,
    input wire logic       slot_req,
    input wire logic       slot_wbit,
    input wire logic       slot_done,
    input wire logic       pulse_on,
    input wire logic       pulse_12v,
    input wire logic [1:0] speed,
    input wire logic       search_on
);
    logic       take;
    logic [7:0] cmd_reg;
    logic [7:0] resp_reg;
    logic [3:0] nslot_reg;
    assign take = rx_valid && rx_ready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= 8'h00;
        end else if (take && !data_mode && !pulse_on && rx_data[7:5] == search_pulse_pkg::FUNC_PULSE) begin
            cmd_reg <= rx_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_reg <= 8'h00;
        end else if (tx_valid && tx_ready) begin
            resp_reg <= tx_data;
        end
    end
    // slots of the byte in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nslot_reg <= 4'h0;
        end else if (take) begin
            nslot_reg <= 4'h0;
        end else if (slot_req && slot_done) begin
            nslot_reg <= nslot_reg + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence search_take;
        take && !data_mode && rx_data[7:5] == search_pulse_pkg::FUNC_SEARCH && rx_data[0];
    endsequence
    sequence pulse_take;
        take && !data_mode && rx_data[7:5] == search_pulse_pkg::FUNC_PULSE
            && rx_data[3:2] == search_pulse_pkg::PULSE_SEL && rx_data[0];
    endsequence
    a_search_flag: assert property (search_take |=> search_on == $past(rx_data[4]))
        else $error("search flag wrong");
    a_speed_now: assert property (search_take |=> speed == $past(rx_data[3:2]))
        else $error("speed late");
    a_search_silent: assert property (search_take |-> ##1 (!tx_valid) [*4])
        else $error("search cmd answered");
    a_pulse_kind: assert property (pulse_take |=> pulse_on && pulse_12v == $past(rx_data[4]))
        else $error("pulse type wrong");
    a_pulse_quiet: assert property (pulse_on |-> !tx_valid)
        else $error("early pulse reply");
    a_pulse_echo: assert property ($fell(pulse_on) && !data_mode |-> tx_valid && tx_data[7:2] == cmd_reg[7:2])
        else $error("pulse echo wrong or late");
    a_term_early: assert property (take && pulse_on && !data_mode && rx_data == search_pulse_pkg::CODE_TERM
        |=> !pulse_on)
        else $error("termination ignored");
    a_end_code: assert property ($fell(pulse_on) && data_mode |-> tx_valid
        && tx_data == (resp_reg[7] ? search_pulse_pkg::CODE_END_HI : search_pulse_pkg::CODE_END_LO))
        else $error("pullup end code wrong");
    a_slot_count: assert property ($rose(tx_valid) && data_mode |-> nslot_reg == (search_on ? 4'hc : 4'h8))
        else $error("slot count wrong");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx not held");
    a_slot_hold: assert property (slot_req && !slot_done |=> slot_req && $stable(slot_wbit))
        else $error("slot not held");
endmodule

// *** testbench/search_pulse_cmds_tb.sv ***
// self-checking bench for the search-assist and pulse command block
`timescale 1ns/1ps
module search_pulse_cmds_tb;
    logic        clk, rst_n, psel, penable, pwrite, data_mode, rx_valid, tx_ready, pulse_end, err;
    logic [11:0] paddr, rpat, wlog;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  rx_data, tx_data, cmd_fwd_byte;
    logic [1:0]  speed, lat;
    logic        pready, pslverr, rx_ready, tx_valid, slot_req, slot_wbit, slot_done, slot_rbit;
    logic        pulse_on, pulse_12v, search_on, cmd_fwd_valid;
    int          num_errors = 0;
    int          num_checks = 0;
    search_pulse_cmds DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_mode(data_mode), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .slot_req(slot_req),
        .slot_wbit(slot_wbit), .slot_done(slot_done), .slot_rbit(slot_rbit), .pulse_on(pulse_on),
        .pulse_12v(pulse_12v), .pulse_end(pulse_end), .speed(speed), .search_on(search_on),
        .cmd_fwd_valid(cmd_fwd_valid), .cmd_fwd_byte(cmd_fwd_byte));
    bus_slaves_model slaves (.clk(clk), .slot_req(slot_req), .slot_wbit(slot_wbit), .rpat(rpat),
        .lat(lat), .slot_done(slot_done), .slot_rbit(slot_rbit), .wlog(wlog));
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd       = prdata;
        err      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        do @(negedge clk); while (rx_ready !== 1'b1);
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask
    // stall one cycle to exercise hold
    task automatic get(input logic [7:0] exp);
        do @(negedge clk); while (tx_valid !== 1'b1);
        check(tx_data, exp);
        @(posedge clk);
        tx_ready <= 1'b1;
        @(posedge clk);
        tx_ready <= 1'b0;
    endtask
    // pulses end quickly: never unlimited
    task automatic fire(input logic v12, input logic term);
        do @(negedge clk); while (pulse_on !== 1'b1);
        check(pulse_12v, v12);
        repeat (2) @(negedge clk);
        check(tx_valid, 1'b0);
        if (term) begin
            send(search_pulse_pkg::CODE_TERM);
        end else begin
            @(posedge clk);
            pulse_end <= 1'b1;
            @(posedge clk);
            pulse_end <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        check(search_on, 1'b0);
        apb(1'b0, search_pulse_pkg::ADDR_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0200);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(err, 1'b1);
        apb(1'b1, search_pulse_pkg::ADDR_STATUS, 32'hffff_ffff);
        check(err, 1'b1);
        apb(1'b1, search_pulse_pkg::ADDR_CTRL, 32'h0000_0000);
        @(negedge clk);
        check(rx_ready, 1'b0);
        apb(1'b1, search_pulse_pkg::ADDR_CTRL, search_pulse_pkg::CTRL_RESET);
        apb(1'b0, search_pulse_pkg::ADDR_CTRL, 32'h0000_0000);
        check(rd, search_pulse_pkg::CTRL_RESET);
    endtask
    task automatic t_search_cmd();
        send(8'hbd);
        repeat (6) @(negedge clk);
        check(tx_valid, 1'b0);
        check(search_on, 1'b1);
        check(speed, 2'h3);
        send(8'hb1);
        @(negedge clk);
        check(speed, 2'h0);
        send(8'hc1);
        @(negedge clk);
        check({cmd_fwd_valid, cmd_fwd_byte}, 9'h1c1);
    endtask
    task automatic t_search_pass();
        data_mode <= 1'b1;
        rpat      <= 12'hbe6;
        send(8'h08);
        get(8'hbc);
        check(wlog, 12'hffb);
        rpat <= 12'hdb6;
        lat  <= 2'h2;
        send(8'h00);
        get(8'haa);
        check(wlog, 12'h6db);
        data_mode <= 1'b0;
        send(8'ha1);
        send(8'hb1);
        data_mode <= 1'b1;
        send(8'h00);
        get(8'h00);
        data_mode <= 1'b0;
        lat       <= 2'h0;
        send(8'ha1);
    endtask
    task automatic t_pulse();
        send(8'hef);
        fire(1'b0, 1'b0);
        get(8'hec);
        data_mode <= 1'b1;
        rpat      <= 12'h081;
        send(8'hff);
        get(8'h81);
        fire(1'b0, 1'b0);
        get(8'hf6);
        rpat <= 12'h001;
        send(8'hff);
        get(8'h01);
        fire(1'b0, 1'b0);
        get(8'h76);
        data_mode <= 1'b0;
        send(8'hed);
        fire(1'b0, 1'b1);
        get(8'hec);
        send(8'hfd);
        fire(1'b1, 1'b1);
        get(8'hfc);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        {rst_n, psel, penable, pwrite, data_mode, rx_valid, tx_ready, pulse_end} = 8'h00;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        rx_data = 8'h00;
        rpat    = 12'h000;
        lat     = 2'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_search_cmd();
        t_search_pass();
        t_pulse();
        tally_and_finish();
    end
    initial begin
        #(50 * 20000);
        num_errors++;
        tally_and_finish();
    end
endmodule
bind search_pulse_cmds search_pulse_asserts chk (.*);
